//--- core/adc_port.sv
// Conversion control and three-state parallel result port of the converter.
`default_nettype none
module adc_port
   import adc_port_pkg::*;
(
   input  wire logic                  clk_in,
   input  wire logic                  rst_n_in,
   input  wire logic                  cs_n_in,
   input  wire logic                  rd_conv_in,
   input  wire logic                  sample_valid_in,
   output logic                       sample_ready_out,
   input  wire adc_port_pkg::result_t sample_in,
   output logic                       sample_hold_out,
   output logic                       busy_n_out,
   output adc_port_pkg::result_t      result_bus_out,
   output logic                       result_bus_oe_out
);
   import adc_port_pkg::*;

   // Digitised codes arrive on the sample stream already in two's complement.
   logic        fifo_valid;
   logic        fifo_pop;
   result_t     fifo_data;

   sample_fifo #(
      .WIDTH (RESULT_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (clk_in),
      .rst_n_in      (rst_n_in),
      .in_valid_in   (sample_valid_in),
      .in_ready_out  (sample_ready_out),
      .in_data_in    (sample_in),
      .out_valid_out (fifo_valid),
      .out_ready_in  (fifo_pop),
      .out_data_out  (fifo_data)
   );

   conv_state_e state;
   conv_state_e next_state;
   logic [5:0]  cnt;
   logic [5:0]  next_cnt;
   logic        cs_q;
   logic        rc_q;
   result_bus_s bus;
   result_bus_s next_bus;
   logic        next_busy_n;
   logic        next_hold;
   logic        start_req;
   logic        done;

   always_comb begin
      // Both strobes are OR'd: a start is either edge with the other low.
      start_req = (cs_q && !cs_n_in && !rd_conv_in)
               || (rc_q && !rd_conv_in && !cs_n_in);
      done = (state == ST_CONV) && (cnt == CONV_LAST) && fifo_valid;
      next_state = state;
      next_cnt = cnt;
      next_busy_n = busy_n_out;
      next_hold = sample_hold_out;
      next_bus.value = bus.value;
      fifo_pop = 1'b0;
      unique case (state)
         ST_IDLE: begin
            if (start_req) begin
               next_state = ST_CONV;
               next_cnt = '0;
               next_busy_n = 1'b0;
               next_hold = 1'b1;
            end
         end
         ST_CONV: begin
            // Further starts are not looked at while converting.
            if (cnt != CONV_LAST) begin
               next_cnt = cnt + 6'h01;
            end
            if (done) begin
               fifo_pop = 1'b1;
               next_bus.value = fifo_data;
               next_state = ST_IDLE;
               next_busy_n = 1'b1;
               next_hold = 1'b0;
            end
         end
      endcase
      // Drivers follow the levels, so edges enable them naturally.
      next_bus.drive_en = !cs_n_in && rd_conv_in && (next_state == ST_IDLE)
                       && !start_req;
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state <= ST_IDLE;
         cnt <= '0;
         cs_q <= 1'b1;
         rc_q <= 1'b1;
         busy_n_out <= 1'b1;
         sample_hold_out <= 1'b0;
         bus <= '{drive_en: 1'b0, value: RESULT_RESET};
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         cs_q <= cs_n_in;
         rc_q <= rd_conv_in;
         busy_n_out <= next_busy_n;
         sample_hold_out <= next_hold;
         bus <= next_bus;
      end
   end

   assign result_bus_out = bus.value;
   assign result_bus_oe_out = bus.drive_en;

   chk_busy_on_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state == ST_IDLE && start_req) |=> !busy_n_out) else $error("busy not low");
   chk_hiz_converting: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !busy_n_out |-> !result_bus_oe_out) else $error("bus driven while busy");
   chk_hiz_select: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $past(cs_n_in) |-> !result_bus_oe_out) else $error("bus driven unselected");
   chk_hiz_convmode: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !$past(rd_conv_in) |-> !result_bus_oe_out) else $error("bus driven in convert");
   chk_rc_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (busy_n_out && !cs_n_in && rc_q && !rd_conv_in) |=> sample_hold_out)
      else $error("rd/conv edge no start");
   chk_cs_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (busy_n_out && !rd_conv_in && cs_q && !cs_n_in) |=> !busy_n_out)
      else $error("select edge no start");
   chk_read_enable: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (busy_n_out && state == ST_IDLE && !cs_n_in && rd_conv_in) |=> result_bus_oe_out)
      else $error("read not enabled");
   chk_data_at_busy: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (!cs_n_in && rd_conv_in && done) |=> (result_bus_oe_out && busy_n_out
      && result_bus_out == $past(fifo_data))) else $error("data not valid at busy rise");
   chk_no_restart: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state == ST_CONV && !done) |=> cnt == $past(cnt) + 6'h01 || cnt == CONV_LAST)
      else $error("conversion restarted");
   chk_min_conv: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $fell(busy_n_out) |-> !busy_n_out[*8]) else $error("conversion too short");
endmodule
`default_nettype wire

//--- core/adc_port_pkg.sv
// Package with constants and types of the converter read and convert port.
`default_nettype none
package adc_port_pkg;
   localparam int          RESULT_WIDTH   = 12;
   localparam int          FIFO_DEPTH     = 8;
   localparam int          CONV_TIME_NS   = 1000;
   localparam int          CLK_PERIOD_NS  = 25;
   localparam int          CONV_CYCLES    = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [11:0] RESULT_RESET   = 12'h000;
   localparam logic [11:0] CODE_POS_FULL  = 12'h7FF;
   localparam logic [11:0] CODE_NEG_FULL  = 12'h800;
   localparam logic [5:0]  CONV_LAST      = 6'(CONV_CYCLES - 1);

   typedef logic [RESULT_WIDTH-1:0] result_t;

   typedef struct packed {
      logic    drive_en;
      result_t value;
   } result_bus_s;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_CONV = 2'b10
   } conv_state_e;
endpackage
`default_nettype wire

//--- core/sample_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides.
`default_nettype none
module sample_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   always_comb begin
      push = in_valid_in && (count != (AW+1)'(DEPTH));
      pop = out_ready_in && (count != '0);
      next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   assign in_ready_out = (count != (AW+1)'(DEPTH));
   assign out_valid_out = (count != '0);
   assign out_data_out = mem[rd_ptr];
endmodule
`default_nettype wire

//--- test/sample_source.sv
// Behavioural analog core model that streams converted codes into the port.
`default_nettype none
module sample_source
   import adc_port_pkg::*;
(
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             ready_in,
   output logic                  valid_out,
   output adc_port_pkg::result_t data_out
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam result_t CODES [10] = '{12'h7FF, 12'h000, 12'h800, 12'hFFF, 12'h123,
                                      12'hABC, 12'h456, 12'h789, 12'h001, 12'hFFE};
   int idx;

   // A code is held until the port accepts it; once the table is spent the
   // data lines show 12'h001, the value the ninth word also carried.
   assign valid_out = rst_n_in && (idx < 10);
   assign data_out  = valid_out ? CODES[idx] : ~CODES[9];

   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         idx <= 0;
      end else if (valid_out && ready_in) begin
         idx <= idx + 1;
      end
   end
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench of the converter read and convert port.
`default_nettype none
module tb_top;
   import adc_port_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic    clk_in = 0, rst_n_in = 0, cs_n = 1, rd_conv = 1;
   logic    s_valid, s_ready, hold, busy_n, oe;
   result_t s_data, result;
   int      n_fail = 0, total_checks = 0, i, cyc;
   localparam result_t EXP [4] = '{12'h7FF, 12'h000, 12'h800, 12'hFFF};

   adc_port uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n), .rd_conv_in(rd_conv),
      .sample_valid_in(s_valid), .sample_ready_out(s_ready), .sample_in(s_data),
      .sample_hold_out(hold), .busy_n_out(busy_n), .result_bus_out(result),
      .result_bus_oe_out(oe));
   sample_source src (.clk_in(clk_in), .rst_n_in(rst_n_in), .ready_in(s_ready),
      .valid_out(s_valid), .data_out(s_data));

   initial begin
      forever #12.5 clk_in = ~clk_in;
   end

   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge clk_in);
   endtask

   task automatic wait_busy(input logic lvl);
      cyc = 0;
      while (busy_n !== lvl && cyc < 100) begin
         cycles(1);
         cyc++;
      end
   endtask

   task automatic conv_rc(input result_t code);
      cs_n = 0;
      cycles(1);
      rd_conv = 0;
      wait_busy(0);
      check("busy_fall", 12'(cyc <= 2), 12'h1);
      check("hold", hold, 12'h1);
      rd_conv = 1;
      cycles(2);
      check("oe_busy", oe, 12'h0);
      rd_conv = 0;
      cycles(1);
      rd_conv = 1;
      cycles(1);
      check("busy_ign", busy_n, 12'h0);
      wait_busy(1);
      check("conv_len", 12'(cyc >= 30 && cyc < 100), 12'h1);
      check("result", result, code);
      check("oe_done", oe, 12'h1);
      check("hold_off", hold, 12'h0);
      cs_n = 1;
      cycles(2);
      check("oe_cs", oe, 12'h0);
      $display("conv_rc done");
   endtask

   task automatic conv_cs(input result_t code);
      rd_conv = 0;
      cycles(1);
      cs_n = 0;
      wait_busy(0);
      check("busy_fall", 12'(cyc <= 2), 12'h1);
      cs_n = 1;
      cycles(1);
      cs_n = 0;
      wait_busy(1);
      check("result", result, code);
      check("oe_rdlow", oe, 12'h0);
      rd_conv = 1;
      cycles(2);
      check("oe_rd", oe, 12'h1);
      cs_n = 1;
      cycles(2);
      check("oe_cs", oe, 12'h0);
      cs_n = 0;
      cycles(2);
      check("oe_csf", oe, 12'h1);
      cs_n = 1;
      cycles(1);
      $display("conv_cs done");
   endtask

   task automatic test_done();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      #50000;
      n_fail++;
      test_done();
   end

   initial begin
      cycles(3);
      rst_n_in = 1;
      check("busy_rst", busy_n, 12'h1);
      check("oe_rst", oe, 12'h0);
      cycles(12);
      check("fifo_full", s_ready, 12'h0);
      $display("reset done");
      for (i = 0; i < 4; i++) begin
         if (i[0])
            conv_cs(EXP[i]);
         else
            conv_rc(EXP[i]);
      end
      test_done();
   end
endmodule
`default_nettype wire
